// >>> verilog/timer_defines.svh
// Register offsets, field positions and reset values of the counter/timer block
`ifndef TIMER_DEFINES_SVH
`define TIMER_DEFINES_SVH

// Wishbone byte offsets, one register per aligned word
`define OFF_CONTROL_STATUS 8'h00
`define OFF_MODE           8'h04
`define OFF_CLOCK_SELECT   8'h08
`define OFF_EXT_IRQ_CONFIG 8'h0c
`define OFF_A_LOW          8'h10
`define OFF_A_HIGH         8'h14
`define OFF_B_LOW          8'h18
`define OFF_B_HIGH         8'h1c
`define OFF_IRQ_ENABLE     8'h20
`define OFF_IRQ_STATUS     8'h24
`define OFF_IRQ_MASK       8'h28

// Control/status fields
`define BIT_TF_B 7
`define BIT_RUN_B 6
`define BIT_TF_A 5
`define BIT_RUN_A 4
// Mode fields, timer B in the upper nibble
`define BIT_GATE_A 3
`define BIT_CT_A 2
`define BIT_GATE_B 7
`define BIT_CT_B 6
// Clock select fields
`define BIT_CLKSEL_A 3
`define BIT_CLKSEL_B 4
// Gate polarity fields
`define BIT_POL_A 3
`define BIT_POL_B 7
// Interrupt enable, status and mask fields
`define BIT_IRQ_A 0
`define BIT_IRQ_B 1

// Reset values
`define RST_BYTE 8'h00
`define RST_IRQ  2'h0

// Prescaler ratios for prescale_field values 0..3
`define PRESCALE_DIV0 8'h04
`define PRESCALE_DIV1 8'h08
`define PRESCALE_DIV2 8'h10
`define PRESCALE_DIV3 8'h20

`endif

// >>> verilog/timer_pkg.sv
// Types shared by the counter/timer design files
package timer_pkg;

  // Two-bit per-timer mode field encoding
  typedef enum logic [1:0] {
    MODE_13BIT,
    MODE_16BIT,
    MODE_RELOAD8,
    MODE_SPLIT
  } timer_mode_t;

  // Result of one counting step of a timer
  typedef struct packed {
    logic [7:0] low;
    logic [7:0] high;
    logic       ovf;
  } step_t;

endpackage : timer_pkg

// >>> verilog/tick_if.sv
// Count-enable pulses passed from the helper modules to the timer core
`timescale 1ns/1ns
`default_nettype none
interface tick_if;
  logic       prescale_tick;  // One-cycle pulse at the prescaled rate
  logic [1:0] fall;           // Falling edge seen on count pins B,A

  modport prescaler (output prescale_tick);
  modport edges     (output fall);
  modport core      (input prescale_tick, input fall);
endinterface : tick_if
`default_nettype wire

// >>> verilog/prescaler.sv
// Divider that makes the prescaled count-enable pulse
`timescale 1ns/1ns
`default_nettype none
module prescaler (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [1:0] prescale_field_i,
  tick_if.prescaler       tick
);
  import timer_pkg::*;
  `include "timer_defines.svh"

  logic [7:0] cnt_q;   // Cycles since the last pulse
  logic [7:0] cnt_d;
  logic       tick_q;  // Registered pulse
  logic       tick_d;
  logic [7:0] div;     // Selected ratio

  // Pick the ratio and count up to it
  always_comb begin
    unique case (prescale_field_i)
      2'h0: div = `PRESCALE_DIV0;
      2'h1: div = `PRESCALE_DIV1;
      2'h2: div = `PRESCALE_DIV2;
      default: div = `PRESCALE_DIV3;
    endcase
    tick_d = 1'b0;
    cnt_d  = cnt_q + 8'h01;
    // Wrap also covers a ratio lowered while counting
    if (cnt_q >= div - 8'h01) begin
      cnt_d  = 8'h00;
      tick_d = 1'b1;
    end
  end

  // Register the divider
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q  <= 8'h00;
      tick_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick.prescale_tick = tick_q;
endmodule : prescaler
`default_nettype wire

// >>> verilog/pin_edges.sv
// Falling-edge detector for the two external count pins
`timescale 1ns/1ns
`default_nettype none
module pin_edges (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [1:0] pins_i,
  tick_if.edges           tick
);
  logic [1:0] prev_q;  // Level seen last cycle
  logic [1:0] prev_d;
  logic [1:0] fall_q;  // Registered high-to-low pulse
  logic [1:0] fall_d;

  // High last cycle, low now means one event
  always_comb begin
    prev_d = pins_i;
    fall_d = prev_q & ~pins_i;
  end

  // Start high so a pin low at reset counts as one event
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_q <= 2'h3;
      fall_q <= 2'h0;
    end else begin
      prev_q <= prev_d;
      fall_q <= fall_d;
    end
  end

  assign tick.fall = fall_q;
endmodule : pin_edges
`default_nettype wire

// >>> verilog/dual_counter_timer.sv
// Two 8051-style counter/timers with a Wishbone register slave
//
// Decided for this implementation: the address map and the Wishbone slave port.
`timescale 1ns/1ns
`default_nettype none
module dual_counter_timer (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Wishbone classic slave
  input  wire logic       wb_cyc_i,
  input  wire logic       wb_stb_i,
  input  wire logic       wb_we_i,
  input  wire logic [7:0] wb_adr_i,
  input  wire logic [3:0] wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]     wb_dat_o,
  output logic            wb_ack_o,
  // External pins
  input  wire logic       count_pin_a_i,
  input  wire logic       count_pin_b_i,
  input  wire logic       gate_pin_a_i,
  input  wire logic       gate_pin_b_i,
  // Processor vectoring acknowledge pulses
  input  wire logic       timer_a_vector_i,
  input  wire logic       timer_b_vector_i,
  // Interrupts
  output logic            timer_a_irq_o,
  output logic            timer_b_irq_o,
  output logic            irq_o
);
  import timer_pkg::*;
  `include "timer_defines.svh"

  // One step of a timer in modes 0..2
  function automatic step_t count_step(input timer_mode_t mode, input logic [7:0] lo,
                                       input logic [7:0] hi);
    step_t r;
    r = '{low: lo, high: hi, ovf: 1'b0};
    unique case (mode)
      MODE_13BIT: begin
        // Upper low-byte bits are left as they are
        {r.high, r.low[4:0]} = {hi, lo[4:0]} + 13'h0001;
        r.ovf = &{hi, lo[4:0]};
      end
      MODE_16BIT: begin
        {r.high, r.low} = {hi, lo} + 16'h0001;
        r.ovf = &{hi, lo};
      end
      default: begin
        // Reload mode; split handled by the caller
        r.low = lo + 8'h01;
        r.ovf = &lo;
        if (r.ovf) begin
          r.low = hi;
        end
      end
    endcase
    return r;
  endfunction : count_step

  tick_if tick ();  // Pulses from helper modules

  logic [7:0] ctl_q, ctl_d;      // Run bits and overflow flags
  logic [7:0] mode_q, mode_d;    // Gate, count select, mode per timer
  logic [7:0] clk_q, clk_d;      // Clock selects and prescale field
  logic [7:0] pol_q, pol_d;      // Gate pin polarities
  logic [7:0] a_lo_q, a_lo_d;    // timer_a_low_byte
  logic [7:0] a_hi_q, a_hi_d;    // timer_a_high_byte
  logic [7:0] b_lo_q, b_lo_d;    // timer_b_low_byte
  logic [7:0] b_hi_q, b_hi_d;    // timer_b_high_byte
  logic [1:0] ien_q, ien_d;      // timer_a/b_irq_enable
  logic [1:0] sts_q, sts_d;      // Sticky overflow events
  logic [1:0] msk_q, msk_d;      // Interrupt mask
  logic       ack_q, ack_d;      // Bus acknowledge
  logic [31:0] rdat_q, rdat_d;   // Read data
  logic       irq_a_q, irq_a_d;  // Timer A request
  logic       irq_b_q, irq_b_d;  // Timer B request
  logic       irq_q, irq_d;      // Combined level interrupt

  timer_mode_t mode_a, mode_b;   // Decoded mode fields
  logic       split;             // Timer A in split mode
  logic       base_a, base_b;    // Internal time base pulses
  logic       tick_a, tick_b;    // Selected count pulses
  logic       en_a, en_b;        // Counting allowed
  logic       en_ah;             // Split high-byte counter allowed
  logic       ovf_a, ovf_b;      // Overflow events into flags
  logic       bus_go;            // Bus cycle taken this edge
  logic       wr;                // Write to lane 0 this edge
  step_t      sa, sb;            // Step results
  logic [7:0] rd;                // Selected read byte

  // Prescaled time base
  prescaler u_prescaler (
    .clk_i            (clk_i),
    .rst_i            (rst_i),
    .prescale_field_i (clk_q[1:0]),
    .tick             (tick.prescaler)
  );

  // External event edges
  pin_edges u_pin_edges (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .pins_i ({count_pin_b_i, count_pin_a_i}),
    .tick   (tick.edges)
  );

  // Decode modes and count enables
  always_comb begin
    mode_a = timer_mode_t'(mode_q[1:0]);
    mode_b = timer_mode_t'(mode_q[5:4]);
    split  = (mode_a == MODE_SPLIT);
    // System clock or prescaled clock
    base_a = clk_q[`BIT_CLKSEL_A] | tick.prescale_tick;
    base_b = clk_q[`BIT_CLKSEL_B] | tick.prescale_tick;
    // Pin edges, at most one per two clocks
    tick_a = mode_q[`BIT_CT_A] ? tick.fall[0] : base_a;
    tick_b = (mode_q[`BIT_CT_B] & ~split) ? tick.fall[1] : base_b;
    // Run and gate pin at its programmed polarity
    en_a = ctl_q[`BIT_RUN_A] & tick_a &
           (~mode_q[`BIT_GATE_A] | (gate_pin_a_i == pol_q[`BIT_POL_A]));
    if (split) begin
      // B is stopped by its own split code and runs without its run bit
      en_b = (mode_b != MODE_SPLIT) & tick_b;
    end else begin
      en_b = ctl_q[`BIT_RUN_B] & tick_b & (mode_b != MODE_SPLIT) &
             (~mode_q[`BIT_GATE_B] | (gate_pin_b_i == pol_q[`BIT_POL_B]));
    end
    // Split high byte: internal base, gated by B's run bit only
    en_ah = split & ctl_q[`BIT_RUN_B] & base_a;
  end

  // Next state of counters, flags and bus
  always_comb begin
    // Take a request only while no answer is pending
    bus_go = wb_cyc_i & wb_stb_i & ~ack_q;
    wr     = bus_go & wb_we_i & wb_sel_i[0];
    ctl_d  = ctl_q;
    mode_d = mode_q;
    clk_d  = clk_q;
    pol_d  = pol_q;
    ien_d  = ien_q;
    msk_d  = msk_q;
    sts_d  = sts_q;
    a_lo_d = a_lo_q;
    a_hi_d = a_hi_q;
    b_lo_d = b_lo_q;
    b_hi_d = b_hi_q;
    ovf_a  = 1'b0;
    ovf_b  = 1'b0;
    // Timer A; run bit alone never touches the count
    sa = count_step(split ? MODE_RELOAD8 : mode_a, a_lo_q, a_hi_q);
    if (split) begin
      sa.low = a_lo_q + 8'h01;  // Plain 8-bit wrap, no reload
    end
    if (en_a) begin
      a_lo_d = sa.low;
      ovf_a  = sa.ovf;
      if (!split) begin
        a_hi_d = sa.high;
      end
    end
    if (en_ah) begin
      a_hi_d = a_hi_q + 8'h01;
      ovf_b  = &a_hi_q;
    end
    // Timer B, silent on its flag while A is split
    sb = count_step(mode_b, b_lo_q, b_hi_q);
    if (en_b) begin
      b_lo_d = sb.low;
      b_hi_d = sb.high;
      if (!split) begin
        ovf_b = sb.ovf;
      end
    end
    // Software writes, one byte per register
    if (wr) begin
      unique case (wb_adr_i)
        `OFF_CONTROL_STATUS: ctl_d = wb_dat_i[7:0];
        `OFF_MODE:           mode_d = wb_dat_i[7:0];
        `OFF_CLOCK_SELECT:   clk_d = wb_dat_i[7:0];
        `OFF_EXT_IRQ_CONFIG: pol_d = wb_dat_i[7:0];
        `OFF_A_LOW:          a_lo_d = wb_dat_i[7:0];
        `OFF_A_HIGH:         a_hi_d = wb_dat_i[7:0];
        `OFF_B_LOW:          b_lo_d = wb_dat_i[7:0];
        `OFF_B_HIGH:         b_hi_d = wb_dat_i[7:0];
        `OFF_IRQ_ENABLE:     ien_d = wb_dat_i[1:0];
        `OFF_IRQ_MASK:       msk_d = wb_dat_i[1:0];
        default: ;
      endcase
    end
    ctl_d[3:0] = 4'h0;  // Unused bits stay zero
    // Vectoring clears the flag
    if (timer_a_vector_i) begin
      ctl_d[`BIT_TF_A] = 1'b0;
    end
    if (timer_b_vector_i) begin
      ctl_d[`BIT_TF_B] = 1'b0;
    end
    // Read of the event register clears it
    if (bus_go && !wb_we_i && wb_adr_i == `OFF_IRQ_STATUS) begin
      sts_d = `RST_IRQ;
    end
    // Hardware set wins over any clear
    if (ovf_a) begin
      ctl_d[`BIT_TF_A] = 1'b1;
      sts_d[`BIT_IRQ_A] = 1'b1;
    end
    if (ovf_b) begin
      ctl_d[`BIT_TF_B] = 1'b1;
      sts_d[`BIT_IRQ_B] = 1'b1;
    end
    // Timer requests follow flag and enable, the combined request follows status and mask
    irq_a_d = ctl_d[`BIT_TF_A] & ien_d[`BIT_IRQ_A];
    irq_b_d = ctl_d[`BIT_TF_B] & ien_d[`BIT_IRQ_B];
    irq_d   = |(sts_d & msk_d);
    // Read mux
    unique case (wb_adr_i)
      `OFF_CONTROL_STATUS: rd = ctl_q;
      `OFF_MODE:           rd = mode_q;
      `OFF_CLOCK_SELECT:   rd = clk_q;
      `OFF_EXT_IRQ_CONFIG: rd = pol_q;
      `OFF_A_LOW:          rd = a_lo_q;
      `OFF_A_HIGH:         rd = a_hi_q;
      `OFF_B_LOW:          rd = b_lo_q;
      `OFF_B_HIGH:         rd = b_hi_q;
      `OFF_IRQ_ENABLE:     rd = {6'h00, ien_q};
      `OFF_IRQ_STATUS:     rd = {6'h00, sts_q};
      `OFF_IRQ_MASK:       rd = {6'h00, msk_q};
      default:             rd = 8'h00;  // Unmapped reads zero
    endcase
    // Answer one cycle after the request is taken
    ack_d  = bus_go;
    rdat_d = bus_go ? {24'h000000, rd} : 32'h00000000;
  end

  // Register all state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl_q   <= `RST_BYTE;
      mode_q  <= `RST_BYTE;
      clk_q   <= `RST_BYTE;
      pol_q   <= `RST_BYTE;
      a_lo_q  <= `RST_BYTE;
      a_hi_q  <= `RST_BYTE;
      b_lo_q  <= `RST_BYTE;
      b_hi_q  <= `RST_BYTE;
      ien_q   <= `RST_IRQ;
      sts_q   <= `RST_IRQ;
      msk_q   <= `RST_IRQ;
      ack_q   <= 1'b0;
      rdat_q  <= 32'h00000000;
      irq_a_q <= 1'b0;
      irq_b_q <= 1'b0;
      irq_q   <= 1'b0;
    end else begin
      ctl_q   <= ctl_d;
      mode_q  <= mode_d;
      clk_q   <= clk_d;
      pol_q   <= pol_d;
      a_lo_q  <= a_lo_d;
      a_hi_q  <= a_hi_d;
      b_lo_q  <= b_lo_d;
      b_hi_q  <= b_hi_d;
      ien_q   <= ien_d;
      sts_q   <= sts_d;
      msk_q   <= msk_d;
      ack_q   <= ack_d;
      rdat_q  <= rdat_d;
      irq_a_q <= irq_a_d;
      irq_b_q <= irq_b_d;
      irq_q   <= irq_d;
    end
  end

  // Outputs straight from flip-flops
  assign wb_ack_o      = ack_q;
  assign wb_dat_o      = rdat_q;
  assign timer_a_irq_o = irq_a_q;
  assign timer_b_irq_o = irq_b_q;
  assign irq_o         = irq_q;
endmodule : dual_counter_timer
`default_nettype wire

// >>> dv/pin_model.sv
// Behavioural model of the external count and gate pins
`timescale 1ns/1ns
`default_nettype none
module pin_model (
  input  wire logic  clk_i,
  output logic [1:0] count_o,  // Count pins B,A, idle high
  output logic [1:0] gate_o    // Gate pins B,A
);
  // Pins start idle so reset sees no event
  initial begin
    count_o = 2'h3;
    gate_o  = 2'h0;
  end

  // Falling edges on one pin, each level held two clocks
  task automatic fall(input int idx, input int n);
    repeat (n) begin
      @(posedge clk_i);
      count_o[idx] <= 1'b0;
      repeat (2) @(posedge clk_i);
      count_o[idx] <= 1'b1;
      @(posedge clk_i);
    end
  endtask : fall

  // Gate pin level change
  task automatic set_gate(input int idx, input logic v);
    @(posedge clk_i);
    gate_o[idx] <= v;
  endtask : set_gate
endmodule : pin_model
`default_nettype wire

// >>> dv/dual_counter_timer_props.sv
// Port-level assertions for the dual counter/timer block
`timescale 1ns/1ns
`default_nettype none
module dual_counter_timer_props (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        timer_a_vector_i,
  input wire logic        timer_b_vector_i,
  input wire logic        timer_a_irq_o,
  input wire logic        timer_b_irq_o,
  input wire logic        irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Answer one cycle after a request
  ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  // Read data zero outside ack, upper lanes always zero
  dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data not zero without ack");
  dat_upper_a: assert property (wb_dat_o[31:8] == 24'h0)
    else $error("read data upper lanes not zero");
  // Outputs quiet through reset and the first edge after
  reset_quiet_a: assert property (disable iff (1'b0) rst_i |=>
    !wb_ack_o && !irq_o && !timer_a_irq_o && !timer_b_irq_o)
    else $error("output active after reset");
  // Requests drop only by vector or software write, the summary request by any bus access
  irq_a_clear_a: assert property ($fell(timer_a_irq_o) |->
    $past(timer_a_vector_i) || $past(wb_cyc_i && wb_stb_i && wb_we_i))
    else $error("timer a request dropped without cause");
  irq_b_clear_a: assert property ($fell(timer_b_irq_o) |->
    $past(timer_b_vector_i) || $past(wb_cyc_i && wb_stb_i && wb_we_i))
    else $error("timer b request dropped without cause");
  irq_sum_clear_a: assert property ($fell(irq_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("summary interrupt dropped without access");

  // Main scenarios reached
  read_seen_c: cover property (wb_ack_o && !wb_we_i);
  irq_rise_c: cover property ($rose(irq_o));
  irq_b_rise_c: cover property ($rose(timer_b_irq_o));
endmodule : dual_counter_timer_props

bind dual_counter_timer dual_counter_timer_props u_dual_counter_timer_props (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .timer_a_vector_i(timer_a_vector_i), .timer_b_vector_i(timer_b_vector_i),
  .timer_a_irq_o(timer_a_irq_o), .timer_b_irq_o(timer_b_irq_o), .irq_o(irq_o));
`default_nettype wire

// >>> dv/dual_counter_timer_tb.sv
// Self-checking bench for the dual counter/timer block
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin err_count++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, got, exp); end end
module dual_counter_timer_tb;
  import timer_pkg::*;
  logic            clk_i, rst_i;        // Clock and reset
  logic            cyc, stb, we, ack;   // Bus control
  logic [7:0]      adr, q;              // Address, last read byte
  logic [31:0]     dat, dat_o;          // Bus data
  logic            vec_a, vec_b;        // Vector pulses
  logic            irq_a, irq_b, irq;   // Requests
  wire logic [1:0] cnt, gt;             // Pins from the model
  int              err_count = 0;       // Mismatches
  int              cmp_count = 0;       // Comparisons
  int              cyc_count = 0;       // Timeout counter

  dual_counter_timer u_dual_counter_timer (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .count_pin_a_i(cnt[0]), .count_pin_b_i(cnt[1]), .gate_pin_a_i(gt[0]),
    .gate_pin_b_i(gt[1]), .timer_a_vector_i(vec_a), .timer_b_vector_i(vec_b),
    .timer_a_irq_o(irq_a), .timer_b_irq_o(irq_b), .irq_o(irq));
  pin_model u_pin_model (.clk_i(clk_i), .count_o(cnt), .gate_o(gt));

  // Free-running 4 ns clock
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  // One classic cycle, held until ack is sampled
  task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= {24'h0, d};
    do @(posedge clk_i); while (ack !== 1'b1);
    q = dat_o[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(a, 1'b1, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    xfer(a, 1'b0, 8'h00);
    `CHK(q, e)
  endtask : rd
  // Wait, then let edge updates settle
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick
  // One-cycle vector pulse
  task automatic vec(input logic b);
    @(posedge clk_i);
    if (b) vec_b <= 1'b1;
    else vec_a <= 1'b1;
    @(posedge clk_i);
    vec_a <= 1'b0;
    vec_b <= 1'b0;
  endtask : vec

  // Verdict and end of run
  task automatic end_sim;
    $display("errors %0d compares %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_sim

  // Hang guard
  always @(posedge clk_i) begin
    cyc_count++;
    if (cyc_count == 5000) begin
      err_count++;
      end_sim();
    end
  end

  initial begin
    {rst_i, cyc, stb, we, vec_a, vec_b} = 6'h20;
    adr = 8'h00;
    dat = 32'h0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i <= 8'h2c; i += 4) rd(8'(i), 8'h00);
    // 16-bit on system clock, interrupts on
    wr(8'h08, 8'h08);
    wr(8'h04, 8'(MODE_16BIT));
    wr(8'h10, 8'hfe);
    wr(8'h14, 8'hff);
    wr(8'h20, 8'h03);
    wr(8'h28, 8'h01);
    tick(4);
    rd(8'h10, 8'hfe);
    wr(8'h00, 8'h10);
    tick(4);
    `CHK(irq_a, 1'b1)
    `CHK(irq, 1'b1)
    rd(8'h00, 8'h30);
    wr(8'h00, 8'h20);
    rd(8'h24, 8'h01);
    tick(1);
    `CHK(irq, 1'b0)
    rd(8'h24, 8'h00);
    vec(1'b0);
    tick(1);
    `CHK(irq_a, 1'b0)
    rd(8'h00, 8'h00);
    // 13-bit counter on pin A
    wr(8'h04, 8'h04);
    wr(8'h10, 8'hff);
    wr(8'h14, 8'hff);
    wr(8'h00, 8'h10);
    u_pin_model.fall(0, 1);
    rd(8'h10, 8'he0);
    rd(8'h14, 8'h00);
    rd(8'h00, 8'h30);
    rd(8'h24, 8'h01);
    u_pin_model.fall(0, 3);
    rd(8'h10, 8'he3);
    // Gated 16-bit counter, gate active high
    wr(8'h00, 8'h00);
    wr(8'h0c, 8'h08);
    wr(8'h04, 8'h0d);
    wr(8'h10, 8'h00);
    wr(8'h00, 8'h10);
    u_pin_model.fall(0, 2);
    rd(8'h10, 8'h00);
    u_pin_model.set_gate(0, 1'b1);
    u_pin_model.fall(0, 2);
    rd(8'h10, 8'h02);
    // Timer B auto-reload on pin B
    wr(8'h00, 8'h00);
    wr(8'h04, 8'h60);
    wr(8'h18, 8'hfe);
    wr(8'h1c, 8'h80);
    wr(8'h00, 8'h40);
    u_pin_model.fall(1, 2);
    rd(8'h18, 8'h80);
    rd(8'h1c, 8'h80);
    rd(8'h00, 8'hc0);
    `CHK({irq_b, irq}, 2'h2)
    vec(1'b1);
    tick(1);
    `CHK(irq_b, 1'b0)
    wr(8'h28, 8'h03);
    tick(1);
    `CHK(irq, 1'b1)
    rd(8'h24, 8'h02);
    u_pin_model.fall(1, 1);
    rd(8'h18, 8'h81);
    // Prescaled time base, ratio 4
    wr(8'h00, 8'h00);
    wr(8'h04, 8'h00);
    wr(8'h08, 8'h00);
    wr(8'h10, 8'h00);
    wr(8'h14, 8'h00);
    wr(8'h00, 8'h10);
    tick(40);
    wr(8'h00, 8'h00);
    xfer(8'h10, 1'b0, 8'h00);
    `CHK(q >= 8'h09 && q <= 8'h0c, 1'b1)
    // Prescaled time base, ratio 8
    wr(8'h08, 8'h01);
    wr(8'h10, 8'h00);
    wr(8'h00, 8'h10);
    tick(80);
    wr(8'h00, 8'h00);
    xfer(8'h10, 1'b0, 8'h00);
    `CHK(q >= 8'h0a && q <= 8'h0b, 1'b1)
    // Split: A high byte runs on timer B's run bit
    wr(8'h08, 8'h08);
    wr(8'h04, 8'h03);
    wr(8'h10, 8'h55);
    wr(8'h14, 8'hff);
    wr(8'h00, 8'h40);
    rd(8'h00, 8'hc0);
    rd(8'h10, 8'h55);
    `CHK(irq_b, 1'b1)
    end_sim();
  end
endmodule : dual_counter_timer_tb
`default_nettype wire
